// *** include/ir_adc_cfg_params.svh ***
`ifndef IR_ADC_CFG_PARAMS_SVH
`define IR_ADC_CFG_PARAMS_SVH
// register indices; the byte address on the bus is index * 4
`define IDX_IR_RECOVERY_CONFIG  8'h1d
`define IDX_IR_INTEGRATION_GAIN 8'h1e
`define IDX_HIGH_RANGE_ENABLE_SELECT     8'h1f
`define IDX_IR_MEAS_CONTROL     8'h20
`define IDX_IR_MEAS_STATUS      8'h21
`define RST_IR_RECOVERY_CONFIG  8'h70
`define RST_IR_INTEGRATION_GAIN 8'h00
`define RST_HIGH_RANGE_ENABLE_SELECT     8'h00
`define REC_LSB                 4
`define REC_MSB                 6
`define GAIN_LSB                0
`define GAIN_MSB                2
`define RANGE_BIT               5
`define MASK_RECOVERY_CONFIG    8'h70
`define MASK_INTEGRATION_GAIN   8'h07
`define MASK_RANGE_SELECT       8'h3f
`define ADC_BASE_PERIOD_NS      50
`define CORE_CLK_PERIOD_NS      25
`define BASE_PERIOD_CYCLES      ((`ADC_BASE_PERIOD_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`endif

// *** include/ir_adc_cfg_pkg.sv ***
package ir_adc_cfg_pkg;
   typedef enum logic [1:0] {
      IDLE,
      RECOVER,
      INTEGRATE
   } meas_state_t;
endpackage : ir_adc_cfg_pkg

// *** rtl/ir_ambient_adc_config.sv ***
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ir_adc_cfg_params.svh"
module ir_ambient_adc_config
   import ir_adc_cfg_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        clkEn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        measStart,
   input  wire logic [15:0] integrationTicks,
   output logic             recoveryActive,
   output logic             adcClkTick,
   output logic             integrating,
   output logic             measDone,
   output logic [2:0]       activeGain,
   output logic             activeHighRange
);
   logic [7:0]  irRecoveryConfig, next_irRecoveryConfig;
   logic [7:0]  irIntegrationGain, next_irIntegrationGain;
   logic [7:0]  irRangeSelect, next_irRangeSelect;
   logic        wrPending, next_wrPending;
   logic [7:0]  wrIndex, next_wrIndex;
   logic [31:0] next_hrdata;
   logic [7:0]  addrIndex;
   logic        addrPhase;
   logic        softStart, next_softStart;
   logic        measBusy;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addrIndex = haddr[9:2];
   assign addrPhase = hsel && hready && htrans[1];

   always_comb begin
      next_irRecoveryConfig  = irRecoveryConfig;
      next_irIntegrationGain = irIntegrationGain;
      next_irRangeSelect     = irRangeSelect;
      next_wrPending         = addrPhase && hwrite;
      next_wrIndex           = addrIndex;
      next_hrdata            = hrdata;
      next_softStart         = 1'b0;
      if (wrPending) begin
         case (wrIndex)
            `IDX_IR_RECOVERY_CONFIG:  next_irRecoveryConfig  = hwdata[7:0] & `MASK_RECOVERY_CONFIG;
            `IDX_IR_INTEGRATION_GAIN: next_irIntegrationGain = hwdata[7:0] & `MASK_INTEGRATION_GAIN;
            `IDX_HIGH_RANGE_ENABLE_SELECT:     next_irRangeSelect     = hwdata[7:0] & `MASK_RANGE_SELECT;
            `IDX_IR_MEAS_CONTROL:     next_softStart         = hwdata[0];
            default: ;
         endcase
      end
      if (addrPhase && !hwrite) begin
         case (addrIndex)
            // forwarded so a read right behind a write sees the new byte
            `IDX_IR_RECOVERY_CONFIG:  next_hrdata = {24'h000000, next_irRecoveryConfig};
            `IDX_IR_INTEGRATION_GAIN: next_hrdata = {24'h000000, next_irIntegrationGain};
            `IDX_HIGH_RANGE_ENABLE_SELECT:     next_hrdata = {24'h000000, next_irRangeSelect};
            `IDX_IR_MEAS_STATUS:      next_hrdata = {28'h0000000, activeHighRange,
                                                     integrating, recoveryActive, measBusy};
            default:                  next_hrdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irRecoveryConfig  <= `RST_IR_RECOVERY_CONFIG;
         irIntegrationGain <= `RST_IR_INTEGRATION_GAIN;
         irRangeSelect     <= `RST_HIGH_RANGE_ENABLE_SELECT;
         wrPending         <= 1'b0;
         wrIndex           <= 8'h00;
         hrdata            <= 32'h00000000;
         softStart         <= 1'b0;
      end else if (clkEn) begin
         irRecoveryConfig  <= next_irRecoveryConfig;
         irIntegrationGain <= next_irIntegrationGain;
         irRangeSelect     <= next_irRangeSelect;
         wrPending         <= next_wrPending;
         wrIndex           <= next_wrIndex;
         hrdata            <= next_hrdata;
         softStart         <= next_softStart;
      end
   end

   // measurement sequencer
   meas_state_t state, next_state;
   logic [2:0]  recCode, next_recCode;
   logic [2:0]  gainLatched, next_gainLatched;
   logic        rangeLatched, next_rangeLatched;
   logic [8:0]  adcClkCount, next_adcClkCount;
   logic [6:0]  divCount, next_divCount;
   logic [1:0]  baseCount, next_baseCount;
   logic [15:0] intCount, next_intCount;
   logic [15:0] intTarget, next_intTarget;
   logic        next_measDone;
   logic [6:0]  divTop;
   logic        baseWrap;
   logic        tick;
   logic [8:0]  recTarget;

   // divider top is 2^gain - 1
   assign divTop    = 7'((8'h01 << gainLatched) - 8'h01);
   assign baseWrap  = (baseCount == 2'(`BASE_PERIOD_CYCLES - 1));
   // one recovery step per divided clock
   assign tick      = baseWrap && (divCount == divTop);
   // 2^(code+2)-1 ticks, code 0 gives 1
   assign recTarget = (recCode == 3'h0) ? 9'h001 : 9'((10'h004 << recCode) - 10'h001);
   assign measBusy  = (state != IDLE);
   assign recoveryActive  = (state == RECOVER);
   assign integrating     = (state == INTEGRATE);
   assign adcClkTick      = measBusy && tick;
   assign activeGain      = gainLatched;
   assign activeHighRange = rangeLatched;

   always_comb begin
      next_state        = state;
      next_recCode      = recCode;
      next_gainLatched  = gainLatched;
      next_rangeLatched = rangeLatched;
      next_adcClkCount  = adcClkCount;
      next_divCount     = divCount;
      next_baseCount    = baseCount;
      next_intCount     = intCount;
      next_intTarget    = intTarget;
      next_measDone     = 1'b0;
      if (measBusy) begin
         next_baseCount = baseWrap ? 2'h0 : 2'(baseCount + 2'h1);
         if (baseWrap) begin
            next_divCount = (divCount == divTop) ? 7'h00 : 7'(divCount + 7'h01);
         end
      end
      case (state)
         IDLE: begin
            if (measStart || softStart) begin
               next_recCode      = irRecoveryConfig[`REC_MSB:`REC_LSB];
               next_gainLatched  = irIntegrationGain[`GAIN_MSB:`GAIN_LSB];
               next_rangeLatched = irRangeSelect[`RANGE_BIT];
               next_intTarget    = integrationTicks;
               next_adcClkCount  = 9'h000;
               next_divCount     = 7'h00;
               next_baseCount    = 2'h0;
               next_state        = RECOVER;
            end
         end
         RECOVER: begin
            if (tick) begin
               if (9'(adcClkCount + 9'h001) == recTarget) begin
                  next_intCount = 16'h0000;
                  next_state    = INTEGRATE;
               end else begin
                  next_adcClkCount = 9'(adcClkCount + 9'h001);
               end
            end
         end
         INTEGRATE: begin
            if (tick) begin
               if (intCount >= intTarget) begin
                  next_measDone = 1'b1;
                  next_state    = IDLE;
               end else begin
                  next_intCount = 16'(intCount + 16'h0001);
               end
            end
         end
         default: next_state = IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state        <= IDLE;
         recCode      <= 3'h0;
         gainLatched  <= 3'h0;
         rangeLatched <= 1'b0;
         adcClkCount  <= 9'h000;
         divCount     <= 7'h00;
         baseCount    <= 2'h0;
         intCount     <= 16'h0000;
         intTarget    <= 16'h0000;
         measDone     <= 1'b0;
      end else if (clkEn) begin
         state        <= next_state;
         recCode      <= next_recCode;
         gainLatched  <= next_gainLatched;
         rangeLatched <= next_rangeLatched;
         adcClkCount  <= next_adcClkCount;
         divCount     <= next_divCount;
         baseCount    <= next_baseCount;
         intCount     <= next_intCount;
         intTarget    <= next_intTarget;
         measDone     <= next_measDone;
      end
   end
endmodule : ir_ambient_adc_config
`default_nettype wire

// *** tb/ir_ambient_adc_config_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module ir_ambient_adc_config_chk (
   input wire logic       core_clk,
   input wire logic       rst_b,
   input wire logic       clkEn,
   input wire logic       measStart,
   input wire logic       recoveryActive,
   input wire logic       adcClkTick,
   input wire logic       integrating,
   input wire logic       measDone,
   input wire logic [2:0] activeGain,
   input wire logic       activeHighRange
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   wire logic busy = recoveryActive | integrating;
   sequence quietThree;
      !adcClkTick [*3];
   endsequence
   AST_START_RECOVER: assert property (!busy && !measDone && measStart && clkEn |=> recoveryActive)
      else $error("start did not enter recovery");
   AST_ONE_PHASE: assert property (!(recoveryActive && integrating))
      else $error("recovery and integration overlap");
   AST_INTEG_AFTER_REC: assert property ($rose(integrating) |-> $past(recoveryActive))
      else $error("integration began without recovery");
   AST_DONE_AFTER_INTEG: assert property (measDone |-> $past(integrating) && !busy)
      else $error("done not after integration");
   AST_DONE_PULSE: assert property (measDone |=> !measDone)
      else $error("done longer than one cycle");
   AST_TICK_BUSY: assert property (adcClkTick |-> busy)
      else $error("tick while idle");
   AST_TICK_DIV1: assert property (adcClkTick && clkEn && activeGain == 3'h0 |=> !adcClkTick)
      else $error("undivided tick period wrong");
   AST_TICK_DIV2: assert property (adcClkTick && clkEn && activeGain == 3'h1 |=> quietThree)
      else $error("divided tick period wrong");
   AST_LATCHED: assert property (busy && $past(busy) |-> $stable(activeGain) && $stable(activeHighRange))
      else $error("latched setting changed mid measurement");
endmodule : ir_ambient_adc_config_chk
bind ir_ambient_adc_config ir_ambient_adc_config_chk i_chk (.core_clk, .rst_b, .clkEn, .measStart,
   .recoveryActive, .adcClkTick, .integrating, .measDone, .activeGain, .activeHighRange);
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ir_adc_cfg_params.svh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errorCnt++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   import ir_adc_cfg_pkg::*;
   localparam logic [31:0] A_REC = {22'h0, `IDX_IR_RECOVERY_CONFIG, 2'b00};
   localparam logic [31:0] A_GAIN = {22'h0, `IDX_IR_INTEGRATION_GAIN, 2'b00};
   localparam logic [31:0] A_RNG = {22'h0, `IDX_HIGH_RANGE_ENABLE_SELECT, 2'b00};
   localparam logic [31:0] A_CTL = {22'h0, `IDX_IR_MEAS_CONTROL, 2'b00};
   localparam logic [31:0] A_STS = {22'h0, `IDX_IR_MEAS_STATUS, 2'b00};
   logic core_clk = 0, rst_b = 0, clkEn = 1, hsel = 0, hwrite = 0, measStart = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2, activeGain;
   logic [15:0] integrationTicks = '0;
   logic hreadyout, hresp, recoveryActive, adcClkTick, integrating, measDone, activeHighRange;
   int errorCnt = 0, nTests = 0, rc, ic;
   always #12.5 core_clk = ~core_clk;
   ir_ambient_adc_config i_ir_ambient_adc_config (.core_clk, .rst_b, .clkEn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .measStart, .integrationTicks, .recoveryActive, .adcClkTick, .integrating, .measDone,
      .activeGain, .activeHighRange);
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1; haddr <= a; hwrite <= w; htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK(hresp, 1'b0)
   endtask : xfer
   task automatic chkRd(input logic [31:0] a, input logic [31:0] e);
      xfer(a, 0, '0);
      `CHK(rd, e)
   endtask : chkRd
   // one measurement; cycles per tick are 2 << gain
   task automatic meas(input logic [2:0] r, input logic [2:0] g, input logic [15:0] t,
                       input logic hr, input logic sw);
      int recCyc;
      recCyc = ((2 ** (r + 2)) - 1 - (r == 0) * 2) * (2 << g);
      xfer(A_REC, 1, {25'h0, r, 4'h0});
      xfer(A_GAIN, 1, {29'h0, g});
      xfer(A_RNG, 1, {26'h0, hr, 5'h0});
      integrationTicks <= t;
      if (sw) begin
         // soft start takes effect one edge after its data phase
         xfer(A_CTL, 1, 32'h1);
         @(posedge core_clk);
      end else begin
         measStart <= 1;
         @(posedge core_clk);
         measStart <= 0;
      end
      rc = 0;
      ic = 0;
      // later register writes must not touch this run; status shows the phase
      fork
         begin
            xfer(A_GAIN, 1, {29'h0, ~g});
            chkRd(A_STS, {28'h0, hr, (recCyc > 2) ? 3'h3 : 3'h5});
         end
      join_none
      for (int k = 0; k < 100000 && measDone !== 1'b1; k++) begin
         @(posedge core_clk);
         rc += (recoveryActive === 1'b1);
         ic += (integrating === 1'b1);
      end
      `CHK(rc, recCyc)
      `CHK(ic, (t + 1) * (2 << g))
      `CHK(activeGain, g)
      `CHK(activeHighRange, hr)
      chkRd(A_STS, {28'h0, hr, 3'h0});
      @(posedge core_clk);
   endtask : meas
   task automatic reportAndStop;
      if (errorCnt == 0 && nTests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : reportAndStop
   initial begin
      #(25 * 90000);
      errorCnt++;
      reportAndStop();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1;
      @(posedge core_clk);
      chkRd(A_REC, 32'h70);
      chkRd(A_GAIN, 32'h0);
      chkRd(A_RNG, 32'h0);
      xfer(A_REC, 1, 32'hff);
      chkRd(A_REC, 32'h70);
      xfer(A_GAIN, 1, 32'hff);
      chkRd(A_GAIN, 32'h07);
      xfer(A_RNG, 1, 32'h1f);
      // read-modify-write sets the range bit, keeps the rest
      chkRd(A_RNG, 32'h1f);
      xfer(A_RNG, 1, rd | 32'h20);
      chkRd(A_RNG, 32'h3f);
      xfer(32'h88, 1, 32'hff);
      chkRd(32'h88, 32'h0);
      // a start pulse while the clock enable is low is never seen
      clkEn <= 0;
      measStart <= 1;
      @(posedge core_clk);
      measStart <= 0;
      @(posedge core_clk);
      clkEn <= 1;
      chkRd(A_STS, 32'h0);
      meas(3'h0, 3'h0, 16'h0, 0, 0);
      meas(3'h1, 3'h1, 16'h3, 1, 0);
      meas(3'h7, 3'h0, 16'h1, 0, 0);
      meas(3'h2, 3'h4, 16'h0, 1, 1);
      meas(3'h0, 3'h7, 16'h2, 0, 1);
      meas(3'h3, 3'h6, 16'h0, 1, 0);
      rst_b <= 0;
      @(posedge core_clk);
      rst_b <= 1;
      @(posedge core_clk);
      chkRd(A_REC, 32'h70);
      chkRd(A_GAIN, 32'h0);
      reportAndStop();
   end
endmodule : tb_top
`default_nettype wire
